// >>> src/spfs_pkg.sv
/*
  spfs_pkg: constants, states and signal groups for the soft power and fault supervisor.
  Assumes a single 100 MHz always-on clock; used with package-qualified names only.
*/
package spfs_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned NUM_RAILS       = 6;
  // response timeout, seconds as printed (about two minutes)
  localparam int unsigned RESP_TIMEOUT_S  = 120;
  // rail monitor settling delay, seconds
  localparam int unsigned RAIL_SETTLE_S   = 1;
  localparam longint unsigned RESP_TIMEOUT_CYC = longint'(RESP_TIMEOUT_S) * CLK_HZ;
  localparam longint unsigned RAIL_SETTLE_CYC  = longint'(RAIL_SETTLE_S) * CLK_HZ;
  localparam int unsigned TMO_W           = 34;
  localparam int unsigned SETTLE_W        = 27;
  localparam logic [5:0] RAIL_RST         = 6'h00;

  // power sequencing states, one-hot
  typedef enum logic [4:0] {
    SPFS_OFF       = 5'h01,
    SPFS_WAKE_REQ  = 5'h02,
    SPFS_ON        = 5'h04,
    SPFS_DOWN_REQ  = 5'h08,
    SPFS_FORCE_OFF = 5'h10
  } spfs_state_t;

  // inputs seen from the host cpu and the frame
  typedef struct packed {
    logic       switch_press;  // one-cycle debounced press of the front switch
    logic       cpu_supply_on; // supply control line driven by the cpu
    logic [5:0] rail_ok;       // comparator per rail, high while above ~90 %
    logic       overtemp;      // over-temperature sense, high when hot
  } spfs_in_t;

  // outputs to the cpu and the supplies
  typedef struct packed {
    logic supply_enable;   // gates both supplies on
    logic wake_request;    // level to cpu: please power up
    logic down_request;    // level to cpu: please power down
    logic overtemp_notify; // level to cpu: over-temperature
    logic uv_fault;        // latched under-voltage fault
    logic ot_fault;        // latched over-temperature fault
    logic forced_off;      // a timeout or an under-voltage forced the supplies off
  } spfs_out_t;
endpackage

// >>> src/spfs_supervisor.sv
/*
  spfs_supervisor: always-on soft power controller with rail and thermal fault handling.
  Assumes sys_clk and rst come from the auxiliary supply domain and inputs are synchronous.
*/
// Function
// - a switch press asks the cpu to wake when off, power down when on
// - force supplies off if the cpu ignores a switch request for two minutes
// - watch six rails, power down at once when one drops below about 90 %
// - over-temperature notifies the cpu instead of cutting power at once
// - force off if the cpu has not powered down two minutes after over-temperature
// - logic runs on the always-on auxiliary domain, whatever the main rails do
// - under-voltage and over-temperature faults stay latched until auxiliary power is lost
// - rail monitoring starts only one second after the supplies come up
// - an under-voltage fault turns off both supplies at once
`timescale 1ns/1ns
module spfs_supervisor #(
  parameter longint unsigned TIMEOUT_CYC = spfs_pkg::RESP_TIMEOUT_CYC,
  parameter longint unsigned SETTLE_CYC  = spfs_pkg::RAIL_SETTLE_CYC
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire spfs_pkg::spfs_in_t  sup_in,
  output spfs_pkg::spfs_out_t      sup_out
);
  spfs_pkg::spfs_state_t           state_reg;
  logic [spfs_pkg::TMO_W-1:0]      tmo_cnt_reg;
  logic [spfs_pkg::SETTLE_W-1:0]   settle_cnt_reg;
  logic                            monitor_en_reg;
  logic                            uv_fault_reg;
  logic                            ot_fault_reg;
  logic                            ot_pending_reg;
  logic                            forced_reg;
  logic                            rail_low;
  logic                            tmo_hit;
  logic                            waiting;
  logic                            supply_en;
  logic                            supply_out_reg;
  logic                            wake_out_reg;
  logic                            down_out_reg;
  logic                            notify_out_reg;
  logic                            uv_out_reg;
  logic                            ot_out_reg;
  logic                            forced_out_reg;

  // a single low rail is enough; gated until the supplies have settled
  assign rail_low  = monitor_en_reg && (sup_in.rail_ok != {spfs_pkg::NUM_RAILS{1'b1}});
  assign tmo_hit   = (64'(tmo_cnt_reg) >= TIMEOUT_CYC - 64'd1);
  assign waiting   = (state_reg == spfs_pkg::SPFS_WAKE_REQ) || (state_reg == spfs_pkg::SPFS_DOWN_REQ)
                     || ot_pending_reg;
  // supplies follow the cpu line unless an under-voltage fault or timeout overrides it
  assign supply_en = sup_in.cpu_supply_on && !uv_fault_reg && !rail_low
                     && (state_reg != spfs_pkg::SPFS_FORCE_OFF);

  // power sequencing; only the always-on clock drives it so it survives rail loss
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= spfs_pkg::SPFS_OFF;
    end else if (uv_fault_reg || rail_low) begin
      state_reg <= spfs_pkg::SPFS_FORCE_OFF;
    end else begin
      case (state_reg)
        spfs_pkg::SPFS_OFF: begin
          if (sup_in.cpu_supply_on) begin
            state_reg <= spfs_pkg::SPFS_ON;
          end else if (sup_in.switch_press) begin
            state_reg <= spfs_pkg::SPFS_WAKE_REQ;
          end
        end
        spfs_pkg::SPFS_WAKE_REQ: begin
          if (sup_in.cpu_supply_on) begin
            state_reg <= spfs_pkg::SPFS_ON;
          end else if (tmo_hit) begin
            state_reg <= spfs_pkg::SPFS_FORCE_OFF;
          end
        end
        spfs_pkg::SPFS_ON: begin
          if (!sup_in.cpu_supply_on) begin
            state_reg <= spfs_pkg::SPFS_OFF;
          end else if (ot_pending_reg && tmo_hit) begin
            state_reg <= spfs_pkg::SPFS_FORCE_OFF;
          end else if (sup_in.switch_press) begin
            state_reg <= spfs_pkg::SPFS_DOWN_REQ;
          end
        end
        spfs_pkg::SPFS_DOWN_REQ: begin
          if (!sup_in.cpu_supply_on) begin
            state_reg <= spfs_pkg::SPFS_OFF;
          end else if (tmo_hit) begin
            state_reg <= spfs_pkg::SPFS_FORCE_OFF;
          end
        end
        spfs_pkg::SPFS_FORCE_OFF: begin
          // leave only once the cpu has dropped its line and no fault is latched, so power cannot bounce back on
          if (!sup_in.cpu_supply_on && !uv_fault_reg && !ot_fault_reg) begin
            state_reg <= spfs_pkg::SPFS_OFF;
          end
        end
        default: begin
          state_reg <= spfs_pkg::SPFS_OFF;
        end
      endcase
    end
  end

  // response timer: runs while a request is outstanding, cleared on completion
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tmo_cnt_reg <= '0;
    end else if (!waiting || state_reg == spfs_pkg::SPFS_FORCE_OFF) begin
      tmo_cnt_reg <= '0;
    end else if (!tmo_hit) begin
      tmo_cnt_reg <= tmo_cnt_reg + spfs_pkg::TMO_W'(1);
    end
  end

  // settle delay restarts whenever the supplies are off
  always_ff @(posedge sys_clk) begin
    if (rst || !supply_en) begin
      settle_cnt_reg <= '0;
      monitor_en_reg <= 1'b0;
    end else if (64'(settle_cnt_reg) >= SETTLE_CYC - 64'd1) begin
      monitor_en_reg <= 1'b1;
    end else begin
      settle_cnt_reg <= settle_cnt_reg + spfs_pkg::SETTLE_W'(1);
    end
  end

  // fault latches; only a reset from loss of auxiliary power clears them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      uv_fault_reg <= 1'b0;
      ot_fault_reg <= 1'b0;
    end else begin
      if (rail_low) begin
        uv_fault_reg <= 1'b1;
      end
      if (sup_in.overtemp) begin
        ot_fault_reg <= 1'b1;
      end
    end
  end

  // thermal request stays pending until the cpu has dropped the supplies
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ot_pending_reg <= 1'b0;
    end else if (sup_in.overtemp && sup_in.cpu_supply_on) begin
      ot_pending_reg <= 1'b1;
    end else if (!sup_in.cpu_supply_on) begin
      ot_pending_reg <= 1'b0;
    end
  end

  // sticky indication that the supervisor had to step in
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      forced_reg <= 1'b0;
    end else if (state_reg == spfs_pkg::SPFS_FORCE_OFF) begin
      forced_reg <= 1'b1;
    end else if (sup_in.switch_press) begin
      forced_reg <= 1'b0;
    end
  end

  // supply gate register; the comb gate above already cut it, this only retimes the pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      supply_out_reg <= 1'b0;
    end else begin
      supply_out_reg <= supply_en;
    end
  end

  // request levels to the cpu, one per direction
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wake_out_reg <= 1'b0;
      down_out_reg <= 1'b0;
    end else begin
      wake_out_reg <= (state_reg == spfs_pkg::SPFS_WAKE_REQ);
      down_out_reg <= (state_reg == spfs_pkg::SPFS_DOWN_REQ);
    end
  end

  // thermal notice follows the latched fault so the cpu cannot miss a short hot spell
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      notify_out_reg <= 1'b0;
    end else begin
      notify_out_reg <= ot_fault_reg;
    end
  end

  // fault copies for the pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      uv_out_reg <= 1'b0;
      ot_out_reg <= 1'b0;
    end else begin
      uv_out_reg <= uv_fault_reg;
      ot_out_reg <= ot_fault_reg;
    end
  end

  // forced shutdown indication copy
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      forced_out_reg <= 1'b0;
    end else begin
      forced_out_reg <= forced_reg;
    end
  end

  // output group gathered from the flip-flops above
  assign sup_out = '{supply_enable:   supply_out_reg,
                     wake_request:    wake_out_reg,
                     down_request:    down_out_reg,
                     overtemp_notify: notify_out_reg,
                     uv_fault:        uv_out_reg,
                     ot_fault:        ot_out_reg,
                     forced_off:      forced_out_reg};
endmodule

// >>> test/spfs_host_model.sv
/*
  spfs_host_model: host cpu that answers power requests dly+1 cycles after they appear.
  Assumes the supervisor's request levels and the same always-on clock.
*/
`timescale 1ns/1ns
module spfs_host_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       wake_req,
  input  wire logic       down_req,
  input  wire logic       ot_note,
  input  wire logic       mute,
  input  wire logic [7:0] dly,
  output logic            cpu_on
);
  logic [7:0] cnt_reg;

  // mute models a hung cpu; the supervisor must then act on its own
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cpu_on  <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (mute || !(wake_req || down_req || ot_note) || cpu_on == wake_req) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg == dly) begin
      cpu_on  <= wake_req;
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule

// >>> test/spfs_props.sv
/*
  spfs_props: checker on the supervisor ports.
  Assumes one clock domain and the design's timeout and settle parameters.
*/
`timescale 1ns/1ns
module spfs_props #(
  parameter longint unsigned TIMEOUT_CYC = 50,
  parameter longint unsigned SETTLE_CYC  = 20
) (
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire spfs_pkg::spfs_in_t  sup_in,
  input wire spfs_pkg::spfs_out_t sup_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  longint unsigned on_reg;
  longint unsigned wait_reg;
  longint unsigned hot_reg;

  // cycles powered, cycles a request stands, cycles hot while powered
  always_ff @(posedge sys_clk) begin
    on_reg   <= (rst || !sup_out.supply_enable) ? 0 : on_reg + 1;
    wait_reg <= (rst || !(sup_out.wake_request || sup_out.down_request)) ? 0 : wait_reg + 1;
    hot_reg  <= (rst || !(sup_out.overtemp_notify && sup_out.supply_enable)) ? 0 : hot_reg + 1;
  end

  property p_wake; sup_in.switch_press && !sup_in.cpu_supply_on && sup_out == '0 |-> ##2 sup_out.wake_request;
  endproperty
  a_wake: assert property (p_wake) else $error("wake request late");
  property p_down; sup_in.switch_press && sup_in.cpu_supply_on && sup_out.supply_enable && !sup_out.wake_request
    && !sup_out.down_request && !sup_out.overtemp_notify |-> ##2 sup_out.down_request; endproperty
  a_down: assert property (p_down) else $error("down request late");
  property p_uv_off; on_reg > SETTLE_CYC + 2 && !(&sup_in.rail_ok) |=> !sup_out.supply_enable; endproperty
  a_uv_off: assert property (p_uv_off) else $error("supplies stayed on");
  property p_uv_set; on_reg > SETTLE_CYC + 2 && !(&sup_in.rail_ok) |-> ##[1:2] sup_out.uv_fault; endproperty
  a_uv_set: assert property (p_uv_set) else $error("uv fault not set");
  property p_settle; on_reg != 0 && on_reg < SETTLE_CYC - 2 |=> !sup_out.uv_fault; endproperty
  a_settle: assert property (p_settle) else $error("uv fault during settle");
  property p_ot; $rose(sup_in.overtemp) && sup_out.supply_enable
    |-> ##[1:2] (sup_out.overtemp_notify && sup_out.supply_enable); endproperty
  a_ot: assert property (p_ot) else $error("no thermal notice");
  property p_tmo; wait_reg <= TIMEOUT_CYC + 4; endproperty
  a_tmo: assert property (p_tmo) else $error("request timeout missed");
  property p_hot; hot_reg <= TIMEOUT_CYC + 4; endproperty
  a_hot: assert property (p_hot) else $error("thermal timeout missed");
  property p_latch; !$past(rst) |-> !($fell(sup_out.uv_fault) || $fell(sup_out.ot_fault)); endproperty
  a_latch: assert property (p_latch) else $error("fault cleared");
  property p_rst; disable iff (1'b0) rst |=> sup_out == '0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  c_forced: cover property (sup_out.forced_off);
  c_uv: cover property (sup_out.uv_fault);
  c_down: cover property (sup_out.down_request);
endmodule
bind spfs_supervisor spfs_props #(.TIMEOUT_CYC(TIMEOUT_CYC), .SETTLE_CYC(SETTLE_CYC)) i_props (
  .sys_clk(sys_clk), .rst(rst), .sup_in(sup_in), .sup_out(sup_out));

// >>> test/tb_soft_power_fault_supervisor.sv
/*
  tb_soft_power_fault_supervisor: directed scenarios for the supervisor.
  Assumes the host model in spfs_host_model and shortened timeouts.
*/
`timescale 1ns/1ns
module tb_soft_power_fault_supervisor;
  localparam int TO = 50;
  logic                sys_clk = 1'b0;
  logic                rst     = 1'b1;
  logic                sw      = 1'b0;
  logic                ot      = 1'b0;
  logic                mute    = 1'b0;
  logic [5:0]          rok     = 6'h3f;
  logic                cpu_on;
  int                  n_mismatch = 0;
  int                  compares   = 0;
  spfs_pkg::spfs_in_t  si;
  spfs_pkg::spfs_out_t so;

  assign si = {sw, cpu_on, rok, ot};
  always #5 sys_clk = ~sys_clk;
  spfs_supervisor #(.TIMEOUT_CYC(TO), .SETTLE_CYC(20)) i_dut (.sys_clk(sys_clk), .rst(rst), .sup_in(si), .sup_out(so));
  spfs_host_model i_cpu (.sys_clk(sys_clk), .rst(rst), .wake_req(so.wake_request), .down_req(so.down_request),
    .ot_note(so.overtemp_notify), .mute(mute), .dly(8'h04), .cpu_on(cpu_on));

  task cyc(input int n); repeat (n) @(posedge sys_clk); endtask
  // the value is copied when chk is called at the edge, before registered outputs land; the 1 ns wait only delays the compare
  task chk(input logic g, input logic e);
    #1 compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task do_reset; cyc(1); rst <= 1'b1; mute <= 1'b0; ot <= 1'b0; rok <= 6'h3f; cyc(16); rst <= 1'b0; cyc(1); endtask
  task press; cyc(1); sw <= 1'b1; cyc(1); sw <= 1'b0; endtask
  task t_wake_down;
    do_reset; press; cyc(2);
    chk(so.wake_request, 1'b1);
    cyc(10);
    chk(so.supply_enable, 1'b1);
    press; cyc(2);
    chk(so.down_request, 1'b1);
    cyc(10);
    chk(so.supply_enable, 1'b0);
  endtask
  task t_timeout;
    do_reset; press; cyc(12); mute <= 1'b1; press; cyc(TO - 10);
    chk(so.supply_enable, 1'b1);
    cyc(20);
    chk(so.supply_enable, 1'b0);
    chk(so.forced_off, 1'b1);
  endtask
  task t_overtemp;
    do_reset; press; cyc(12); mute <= 1'b1; ot <= 1'b1; cyc(3);
    chk(so.overtemp_notify, 1'b1);
    chk(so.supply_enable, 1'b1);
    cyc(TO + 10);
    chk(so.supply_enable, 1'b0);
    press; cyc(20);
    chk(so.ot_fault, 1'b1);
    chk(so.wake_request, 1'b0);
  endtask
  // each rail alone: a dip while settling is ignored, a later one trips
  task t_rail;
    for (int r = 0; r < 6; r++) begin
      do_reset; press; cyc(10); rok[r] <= 1'b0; cyc(2); rok[r] <= 1'b1;
      chk(so.supply_enable, 1'b1);
      cyc(30); rok[r] <= 1'b0; cyc(2);
      chk(so.supply_enable, 1'b0);
      chk(so.uv_fault, 1'b1);
    end
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    t_wake_down;
    t_timeout;
    t_overtemp;
    t_rail;
    wrap_up;
  end
  // about fifteen times the expected run of roughly 650 cycles
  initial begin
    #100000;
    n_mismatch++;
    wrap_up;
  end
endmodule
